// File: tcp_cfg.svh
// Constants for the general-purpose timer: reload values, limits, interrupt source codes.
// Assumes inclusion by bare name from the timer package and design files.
// Functional notes
// - Event-counter mode counts timer input edges chosen by polarity; no prescaler.
// - Comparator-counter mode counts comparator output edges chosen by polarity; no prescaler.
// - Counter modes: at reload value interrupt, load count 0001h, keep counting.
// - Counter and capture modes: enabled output inverts each reload, starts at polarity.
// - Counter modes: polarity also fixes initial output level, even with output disabled; the code holds o_tout low while i_out_en is low.
// - Software start count serves only the first pass; later passes start at 0001h.
// - PWM: toggle at match; at reload interrupt, count to 0001h, continue.
// - PWM output starts at polarity, inverts at match, returns at reload.
// - Dual PWM drives a second pin with the complement of the primary output.
// - Dual PWM delays each rising transition on both pins by 0 to 128 clocks.
// - High-time fraction: (reload-match)/reload at polarity 0, match/reload at 1.
// - Capture modes: selected input edge copies the count into the match register.
// - Capture modes: source config picks interrupts on capture, reload, or both.
// - Capture flag clears on reload interrupt, sets on capture interrupt.
// - Input edge is synchronised; capture lands 2 to 3 clocks after the event.
// - Capture mode counts freely with wrap; capture and reload interrupt without reset.
// - Capture-restart: first of capture or reload interrupts, reloads 0001h, continues.
// - Capture/compare waits for first edge; later edges and compare restart at 0001h.
// - Compare mode interrupts and inverts output at compare value, wraps without reset.
`ifndef TCP_CFG_SVH
`define TCP_CFG_SVH

`define TCP_RESTART_CNT 16'h0001
`define TCP_COUNT_RST 16'h0001
`define TCP_PWM_RST 16'h0000
`define TCP_DB_MAX 8'h80
`define TCP_DB_NONE 8'h00
`define TCP_IRQ_CAPTURE_ONLY 2'h2
`define TCP_IRQ_RELOAD_ONLY 2'h3

`endif

// File: tcp_pkg.sv
// Types shared by the timer and its deadband unit.
// Assumes the constants header sits in the include path.
`default_nettype none
package tcp_pkg;
  `include "tcp_cfg.svh"

  typedef enum logic [3:0] {
    TCP_M_ONESHOT = 4'h0,
    TCP_M_CONT = 4'h1,
    TCP_M_COUNTER = 4'h2,
    TCP_M_PWM_SINGLE = 4'h3,
    TCP_M_CAPTURE = 4'h4,
    TCP_M_COMPARE = 4'h5,
    TCP_M_GATED = 4'h6,
    TCP_M_CAPT_CMP = 4'h7,
    TCP_M_TRIG_ONESHOT = 4'h8,
    TCP_M_CMP_COUNTER = 4'h9,
    TCP_M_PWM_DUAL = 4'ha,
    TCP_M_CAPT_RESTART = 4'hb
  } tcp_mode_t;

  typedef struct packed {
    logic s1_tin;
    logic s2_tin;
    logic pv_tin;
    logic s1_cmp;
    logic s2_cmp;
    logic pv_cmp;
    logic [6:0] presc;
    logic [15:0] count;
    logic [15:0] pwm;
    logic tout;
    logic armed;
    logic irq;
    logic capflag;
  } tcp_state_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic out;
  } tcp_db_state_t;
endpackage
`default_nettype wire

// File: tcp_db_if.sv
// Carrier between the timer core and one deadband unit.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none
interface tcp_db_if;
  logic raw;
  logic [7:0] delay;
  logic out;
  modport ctrl (output raw, output delay, input out);
  modport unit (input raw, input delay, output out);
endinterface
`default_nettype wire

// File: tcp_deadband.sv
// Deadband unit: passes falling edges at once, holds rising edges back by a clock count.
// Assumes raw level and delay come from logic on the same clock.
`timescale 1ns/10ps
`default_nettype none
module tcp_deadband (
  input wire logic i_clk,
  input wire logic i_rst,
  tcp_db_if.unit db
);
  import tcp_pkg::*;

  tcp_db_state_t st_r;
  tcp_db_state_t st_nxt;

  // ----------------------------------------
  // Delay counter
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    if (!db.raw) begin
      st_nxt.cnt = 8'h00;
      st_nxt.out = 1'b0;
    end else if (st_r.cnt >= db.delay) begin
      st_nxt.out = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign db.out = st_r.out;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  chk_db_fall_fast: assert property (!db.raw |=> !db.out)
    else $error("deadband output stayed active after raw fell");
  chk_db_rise_held: assert property (
    (db.raw && !st_r.out && st_r.cnt == 8'h00 && db.delay == 8'h02)
      ##1 db.raw |=> !db.out)
    else $error("deadband rising edge passed too early");
endmodule
`default_nettype wire

// File: tcp_timer.sv
// General-purpose 16-bit timer: counter, PWM, capture and compare modes.
// Assumes control fields come from same-clock logic; pins are asynchronous.
`timescale 1ns/10ps
`default_nettype none
`include "tcp_cfg.svh"
module tcp_timer (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_enable,
  input wire tcp_pkg::tcp_mode_t i_mode,
  input wire logic [2:0] i_prescale,
  input wire logic i_output_polarity_select,
  input wire logic i_out_en,
  input wire logic [1:0] i_interrupt_source_config,
  input wire logic [7:0] i_deadband_delay,
  input wire logic [15:0] i_reload,
  input wire logic i_count_wr,
  input wire logic [15:0] i_count_wdata,
  input wire logic i_pwm_wr,
  input wire logic [15:0] i_pwm_wdata,
  input wire logic i_timer_in,
  input wire logic i_comp_in,
  output logic [15:0] o_count,
  output logic [15:0] o_pwm_match,
  output logic o_irq,
  output logic o_capture_interrupt_flag,
  output logic o_tout,
  output logic o_tout_n
);
  import tcp_pkg::*;

  tcp_state_t st_r;
  tcp_state_t st_nxt;

  logic pol;
  logic tin_edge;
  logic cmp_edge;
  logic [6:0] presc_lim;
  logic presc_tick;
  logic reload_hit;
  logic [15:0] count_inc;
  logic is_capture;
  logic is_dual;
  logic rl_ev;
  logic cap_ev;
  logic allow_rl;
  logic allow_cap;

  assign pol = i_output_polarity_select;

  // ----------------------------------------
  // Edge selection and prescaler
  // ----------------------------------------
  // Edges are taken only after the second synchroniser stage
  assign tin_edge = pol ? (st_r.pv_tin & ~st_r.s2_tin) : (~st_r.pv_tin & st_r.s2_tin);
  assign cmp_edge = pol ? (st_r.pv_cmp & ~st_r.s2_cmp) : (~st_r.pv_cmp & st_r.s2_cmp);
  assign presc_lim = 7'((8'h01 << i_prescale) - 8'h01);
  assign presc_tick = (st_r.presc == presc_lim);
  assign reload_hit = (st_r.count == i_reload);
  assign count_inc = st_r.count + 16'h0001;
  assign is_capture = (i_mode == TCP_M_CAPTURE) || (i_mode == TCP_M_CAPT_RESTART)
                      || (i_mode == TCP_M_CAPT_CMP);
  assign is_dual = (i_mode == TCP_M_PWM_DUAL);

  // Source config only filters interrupts in the capture modes
  always_comb begin
    allow_rl = 1'b1;
    allow_cap = 1'b1;
    if (is_capture) begin
      allow_rl = (i_interrupt_source_config != `TCP_IRQ_CAPTURE_ONLY);
      allow_cap = (i_interrupt_source_config != `TCP_IRQ_RELOAD_ONLY);
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.irq = 1'b0;
    rl_ev = 1'b0;
    cap_ev = 1'b0;
    st_nxt.s1_tin = i_timer_in;
    st_nxt.s2_tin = st_r.s1_tin;
    st_nxt.pv_tin = st_r.s2_tin;
    st_nxt.s1_cmp = i_comp_in;
    st_nxt.s2_cmp = st_r.s1_cmp;
    st_nxt.pv_cmp = st_r.s2_cmp;
    if (i_pwm_wr) begin
      st_nxt.pwm = i_pwm_wdata;
    end
    if (!i_enable) begin
      // Idle output rests at the polarity level, ready for the first pass
      st_nxt.presc = 7'h00;
      st_nxt.tout = pol;
      st_nxt.armed = 1'b0;
    end else begin
      st_nxt.presc = presc_tick ? 7'h00 : st_r.presc + 7'h01;
      unique case (i_mode)
        TCP_M_COUNTER: begin
          if (tin_edge) begin
            if (reload_hit) begin
              st_nxt.count = `TCP_RESTART_CNT;
              st_nxt.tout = ~st_r.tout;
              rl_ev = 1'b1;
            end else begin
              st_nxt.count = count_inc;
            end
          end
        end
        TCP_M_CMP_COUNTER: begin
          if (cmp_edge) begin
            if (reload_hit) begin
              st_nxt.count = `TCP_RESTART_CNT;
              st_nxt.tout = ~st_r.tout;
              rl_ev = 1'b1;
            end else begin
              st_nxt.count = count_inc;
            end
          end
        end
        TCP_M_PWM_SINGLE, TCP_M_PWM_DUAL: begin
          if (presc_tick) begin
            if (reload_hit) begin
              st_nxt.count = `TCP_RESTART_CNT;
              st_nxt.tout = pol;
              rl_ev = 1'b1;
            end else begin
              st_nxt.count = count_inc;
              if (st_r.count == st_r.pwm) begin
                st_nxt.tout = ~pol;
              end
            end
          end
        end
        TCP_M_CAPTURE: begin
          if (presc_tick) begin
            st_nxt.count = count_inc;
            if (reload_hit) begin
              st_nxt.tout = ~st_r.tout;
              rl_ev = 1'b1;
            end
          end
          if (tin_edge) begin
            st_nxt.pwm = st_r.count;
            cap_ev = 1'b1;
          end
        end
        TCP_M_CAPT_RESTART, TCP_M_CAPT_CMP: begin
          if (i_mode == TCP_M_CAPT_CMP && !st_r.armed) begin
            st_nxt.armed = tin_edge;
          end else if (tin_edge) begin
            st_nxt.pwm = st_r.count;
            st_nxt.count = `TCP_RESTART_CNT;
            cap_ev = 1'b1;
          end else if (presc_tick) begin
            if (reload_hit) begin
              st_nxt.count = `TCP_RESTART_CNT;
              st_nxt.tout = ~st_r.tout;
              rl_ev = 1'b1;
            end else begin
              st_nxt.count = count_inc;
            end
          end
        end
        TCP_M_COMPARE: begin
          if (presc_tick) begin
            st_nxt.count = count_inc;
            if (reload_hit) begin
              st_nxt.tout = ~st_r.tout;
              rl_ev = 1'b1;
            end
          end
        end
        // One-shot, continuous and gated modes are not built here; timer holds
        TCP_M_ONESHOT, TCP_M_CONT, TCP_M_GATED, TCP_M_TRIG_ONESHOT: begin
          st_nxt.count = st_r.count;
        end
        default: begin
          st_nxt.count = st_r.count;
        end
      endcase
    end
    st_nxt.irq = (rl_ev && allow_rl) || (cap_ev && allow_cap);
    // Capture wins when both land in one cycle
    if (cap_ev && allow_cap) begin
      st_nxt.capflag = 1'b1;
    end else if (rl_ev && allow_rl) begin
      st_nxt.capflag = 1'b0;
    end
    // A software load only seeds the current pass
    if (i_count_wr) begin
      st_nxt.count = i_count_wdata;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= '0;
      st_r.count <= `TCP_COUNT_RST;
      st_r.pwm <= `TCP_PWM_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs and deadband
  // ----------------------------------------
  tcp_db_if db_p ();
  tcp_db_if db_n ();

  // Deadband only in dual mode; single mode keeps one cycle of latency on the primary path and holds the complement low
  assign db_p.raw = st_r.tout & i_out_en;
  assign db_n.raw = ~st_r.tout & i_out_en & is_dual;
  assign db_p.delay = !is_dual ? `TCP_DB_NONE
                      : (i_deadband_delay > `TCP_DB_MAX ? `TCP_DB_MAX : i_deadband_delay);
  assign db_n.delay = db_p.delay;

  tcp_deadband u_db_p (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .db(db_p.unit)
  );

  tcp_deadband u_db_n (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .db(db_n.unit)
  );

  assign o_count = st_r.count;
  assign o_pwm_match = st_r.pwm;
  assign o_irq = st_r.irq;
  assign o_capture_interrupt_flag = st_r.capflag;
  assign o_tout = db_p.out;
  assign o_tout_n = db_n.out;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_pin_rise;
    !i_timer_in ##1 i_timer_in;
  endsequence

  sequence s_pwm_reload;
    i_enable && (i_mode == TCP_M_PWM_SINGLE) && presc_tick && reload_hit && !i_count_wr;
  endsequence

  chk_ev_count_step: assert property (
    (i_enable && i_mode == TCP_M_COUNTER && tin_edge && !reload_hit && !i_count_wr)
      |=> o_count == $past(o_count) + 16'h0001)
    else $error("event counter did not step on input edge");
  chk_cmp_count_step: assert property (
    (i_enable && i_mode == TCP_M_CMP_COUNTER && cmp_edge && !reload_hit && !i_count_wr)
      |=> o_count == $past(o_count) + 16'h0001)
    else $error("comparator counter did not step on edge");
  chk_counter_reload: assert property (
    (i_enable && i_mode == TCP_M_COUNTER && tin_edge && reload_hit && !i_count_wr)
      |=> o_count == 16'h0001 && o_irq && st_r.tout != $past(st_r.tout))
    else $error("counter reload missed restart, interrupt or toggle");
  chk_idle_level: assert property (
    !i_enable ##1 (!i_enable && $stable(pol)) |-> st_r.tout == pol)
    else $error("idle output level does not follow polarity");
  chk_pwm_reload_seq: assert property (
    s_pwm_reload |=> o_count == 16'h0001 && o_irq && st_r.tout == $past(pol))
    else $error("PWM reload missed restart or interrupt");
  chk_pwm_match_level: assert property (
    (i_enable && i_mode == TCP_M_PWM_SINGLE && presc_tick && !reload_hit
      && st_r.count == st_r.pwm) |=> st_r.tout == !$past(pol))
    else $error("PWM output did not invert at match");
  chk_never_both_on: assert property (!(o_tout && o_tout_n))
    else $error("primary and complement active together");
  chk_capture_store: assert property (
    (i_enable && i_mode == TCP_M_CAPTURE && tin_edge)
      |=> o_pwm_match == $past(o_count)
        && (o_capture_interrupt_flag || !$past(allow_cap)))
    else $error("capture did not store count");
  chk_sync_latency: assert property (
    (s_pin_rise ##0 !pol) ##1 !pol [*2] |-> tin_edge)
    else $error("input edge not seen two clocks after pin rise");
  chk_free_wrap: assert property (
    (i_enable && i_mode == TCP_M_CAPTURE && presc_tick && o_count == 16'hffff && !i_count_wr)
      |=> o_count == 16'h0000)
    else $error("capture mode did not wrap to zero");
  chk_restart_cap: assert property (
    (i_enable && i_mode == TCP_M_CAPT_RESTART && tin_edge && !i_count_wr)
      |=> o_count == 16'h0001 && o_pwm_match == $past(o_count))
    else $error("capture restart did not restart count");
  chk_cc_hold: assert property (
    (i_enable && i_mode == TCP_M_CAPT_CMP && !st_r.armed && !i_count_wr)
      |=> o_count == $past(o_count))
    else $error("capture/compare counted before first edge");
  chk_compare_nores: assert property (
    (i_enable && i_mode == TCP_M_COMPARE && presc_tick && reload_hit && !i_count_wr)
      |=> o_irq && o_count == $past(o_count) + 16'h0001)
    else $error("compare mode reset or missed interrupt");
endmodule
`default_nettype wire

// File: tcp_pin_model.sv
// Far-side model: the timer input pin and the comparator output.
// Assumes the caller enters its task just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module tcp_pin_model (
  input wire logic i_clk,
  output logic o_timer_in,
  output logic o_comp_in
);
  initial begin
    o_timer_in = 1'b0;
    o_comp_in = 1'b0;
  end
  // One full pulse; both levels are held four clocks, never faster
  task automatic pulse(input logic comp);
    repeat (2) begin
      if (comp) begin
        o_comp_in = ~o_comp_in;
      end else begin
        o_timer_in = ~o_timer_in;
      end
      repeat (4) @(posedge i_clk);
      #1;
    end
  endtask
endmodule
`default_nettype wire

// File: tb.sv
// Testbench for the timer: counter, PWM, capture and compare scenarios.
// Assumes the package, the timer and the pin model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import tcp_pkg::*;
  // ----------------
  // Stimulus
  // ----------------
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic en = 1'b0;
  tcp_mode_t mode = TCP_M_COUNTER;
  logic [2:0] presc = 3'h0;
  logic pol = 1'b0;
  logic oen = 1'b1;
  logic [1:0] icfg = 2'h0;
  logic [7:0] db = 8'h00;
  logic [15:0] rld = 16'h0003;
  logic cwr = 1'b0;
  logic [15:0] cwd = 16'h0000;
  logic pwr = 1'b0;
  logic [15:0] pwd = 16'h0000;
  wire tin;
  wire cin;
  logic [15:0] cnt, pwm, c0;
  logic irq, flag, tout, tout_n;
  logic [1:0] cfgs [3] = '{2'h0, 2'h2, 2'h3};
  int err_count = 0;
  int cmp_count = 0;
  int irq_n = 0;
  int hi, hn, ov, k, j;

  tcp_timer tcp_timer_i (.i_clk(i_clk), .i_rst(i_rst), .i_enable(en), .i_mode(mode),
    .i_prescale(presc), .i_output_polarity_select(pol), .i_out_en(oen),
    .i_interrupt_source_config(icfg), .i_deadband_delay(db), .i_reload(rld),
    .i_count_wr(cwr), .i_count_wdata(cwd), .i_pwm_wr(pwr), .i_pwm_wdata(pwd),
    .i_timer_in(tin), .i_comp_in(cin), .o_count(cnt), .o_pwm_match(pwm), .o_irq(irq),
    .o_capture_interrupt_flag(flag), .o_tout(tout), .o_tout_n(tout_n));
  tcp_pin_model tcp_pin_model_i (.i_clk(i_clk), .o_timer_in(tin), .o_comp_in(cin));

  initial begin
    forever #5 i_clk = ~i_clk;
  end
  // Interrupt pulses last one cycle; tallied at the falling edge, clear of the launch
  always @(negedge i_clk) begin
    if (irq === 1'b1) irq_n <= irq_n + 1;
  end
  initial begin
    repeat (6000) @(posedge i_clk);
    err_count++;
    wrap_up();
  end

  task tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Disable first, then change mode fields and the start count
  task setup(input tcp_mode_t m, input logic p, input logic [1:0] ic,
             input logic [15:0] r, input logic [15:0] c);
    en = 1'b0;
    tick(1);
    mode = m;
    pol = p;
    icfg = ic;
    rld = r;
    cwr = 1'b1;
    cwd = c;
    tick(1);
    cwr = 1'b0;
    en = 1'b1;
    tick(1);
  endtask
  task meas(input int n);
    hi = 0;
    hn = 0;
    ov = 0;
    repeat (n) begin
      @(posedge i_clk);
      #1;
      hi += (tout === 1'b1);
      hn += (tout_n === 1'b1);
      ov += (tout === 1'b1 && tout_n === 1'b1);
    end
  endtask
  task wrap_up;
    $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------
  // Tests
  // ----------------
  initial begin
    tick(16);
    i_rst = 1'b0;
    tick(2);
    chk(cnt, 16'h0001, "count after reset");
    chk(pwm, 16'h0000, "match after reset");
    setup(TCP_M_COUNTER, 1'b0, 2'h0, 16'h0003, 16'h0002);
    tcp_pin_model_i.pulse(1'b0);
    chk(cnt, 16'h0003, "rising edge counted");
    chk(16'(tout), 16'h0000, "initial output level");
    j = irq_n;
    tcp_pin_model_i.pulse(1'b0);
    chk(cnt, 16'h0001, "count reloaded");
    chk(16'(irq_n - j), 16'h0001, "reload interrupt");
    chk(16'(tout), 16'h0001, "output inverted");
    tcp_pin_model_i.pulse(1'b0);
    chk(cnt, 16'h0002, "second pass start");
    setup(TCP_M_CMP_COUNTER, 1'b1, 2'h0, 16'h0007, 16'h0005);
    chk(16'(tout), 16'h0001, "initial output high");
    tcp_pin_model_i.pulse(1'b1);
    tcp_pin_model_i.pulse(1'b0);
    chk(cnt, 16'h0006, "comparator falling edge only");
    $display("test counters finished");
    // Match 1 of reload 4 gives three quarters or one quarter high time
    pwr = 1'b1;
    pwd = 16'h0001;
    tick(1);
    pwr = 1'b0;
    for (k = 0; k < 2; k++) begin
      setup(TCP_M_PWM_SINGLE, k[0], 2'h0, 16'h0004, 16'h0001);
      tick(8);
      j = irq_n;
      meas(40);
      chk(16'(hi), k ? 16'h000a : 16'h001e, "pwm high time");
      chk(16'(irq_n - j), 16'h000a, "pwm reload interrupts");
      chk(16'(hn), 16'h0000, "no complement in single mode");
    end
    $display("test pwm single finished");
    pwr = 1'b1;
    pwd = 16'h0004;
    tick(1);
    pwr = 1'b0;
    for (k = 0; k < 2; k++) begin
      db = k ? 8'h02 : 8'h00;
      setup(TCP_M_PWM_DUAL, 1'b0, 2'h0, 16'h0008, 16'h0001);
      tick(16);
      meas(80);
      chk(16'(hi), k ? 16'h0014 : 16'h0028, "primary high time");
      chk(16'(hn), k ? 16'h0014 : 16'h0028, "complement high time");
      chk(16'(ov), 16'h0000, "outputs never both high");
    end
    $display("test pwm dual finished");
    for (k = 0; k < 3; k++) begin
      setup(TCP_M_CAPTURE, 1'b0, cfgs[k], 16'h0040, 16'h0010);
      j = irq_n;
      c0 = cnt;
      tcp_pin_model_i.pulse(1'b0);
      chk(16'((pwm - c0) inside {16'h0002, 16'h0003}), 16'h0001, "capture delay");
      tick(60);
      chk(16'(cnt > 16'h0040), 16'h0001, "no restart at reload");
      chk(16'(irq_n - j), k ? 16'h0001 : 16'h0002, "interrupt sources");
      chk(16'(flag), (k == 1) ? 16'h0001 : 16'h0000, "capture flag");
      chk(16'(tout), 16'h0001, "output inverted at reload");
    end
    $display("test capture finished");
    setup(TCP_M_CAPT_RESTART, 1'b0, 2'h0, 16'h0040, 16'h0010);
    j = irq_n;
    tcp_pin_model_i.pulse(1'b0);
    chk(16'(cnt < 16'h0010), 16'h0001, "restart on capture");
    tick(70);
    chk(16'(irq_n - j), 16'h0002, "capture then reload");
    setup(TCP_M_CAPT_CMP, 1'b0, 2'h0, 16'h0040, 16'h0010);
    tick(5);
    chk(cnt, 16'h0010, "held until first edge");
    c0 = pwm;
    j = irq_n;
    tcp_pin_model_i.pulse(1'b0);
    chk(pwm, c0, "first edge only arms");
    chk(16'(irq_n - j), 16'h0000, "no interrupt on arming");
    tcp_pin_model_i.pulse(1'b0);
    chk(16'(cnt < 16'h0010), 16'h0001, "later edge restarts");
    chk(16'(irq_n - j), 16'h0001, "later edge interrupts");
    $display("test capture restart finished");
    setup(TCP_M_COMPARE, 1'b0, 2'h0, 16'h0020, 16'h0010);
    j = irq_n;
    tick(30);
    chk(16'(cnt > 16'h0020), 16'h0001, "compare keeps counting");
    chk(16'(irq_n - j), 16'h0001, "compare interrupt");
    chk(16'(tout), 16'h0001, "compare output inverted");
    oen = 1'b0;
    tick(2);
    chk(16'(tout), 16'h0000, "output off without alternate function");
    oen = 1'b1;
    for (k = 0; k < 2; k++) begin
      setup(k ? TCP_M_CAPTURE : TCP_M_COMPARE, 1'b0, 2'h0, 16'h0020, 16'hfffe);
      tick(4);
      chk(16'(cnt < 16'h0008), 16'h0001, "wrap to zero");
      chk(cnt, 16'h0003, "free count after wrap");
    end
    // Divide by four: first tick lands four clocks after enable
    presc = 3'h2;
    setup(TCP_M_COMPARE, 1'b0, 2'h0, 16'h0020, 16'h0010);
    tick(16);
    chk(cnt, 16'h0014, "prescaled count");
    presc = 3'h0;
    $display("test compare finished");
    wrap_up();
  end
endmodule
`default_nettype wire
